// ### verilog/ccra_core.v
// Core register set, operand addressing and memory map of the 8-bit core
`timescale 1ns/10ps
`default_nettype none
`include "ccra_map.vh"

module ccra_core (
   input  wire        sys_clk,
   input  wire        reset,
   input  wire        op_valid,
   input  wire [3:0]  op_code,
   input  wire [2:0]  op_mode,
   input  wire [7:0]  op_addr,
   input  wire [7:0]  op_data,
   input  wire [7:0]  code_rdata,
   output wire        op_ready,
   output reg         op_done_reg,
   output reg  [7:0]  rd_data_reg,
   output reg  [15:0] program_counter_reg,
   output reg  [15:0] code_addr_reg,
   output reg         code_rd_reg
);

   localparam ST_IDLE = 1'b0;               // Ready for an operation
   localparam ST_CODE = 1'b1;               // Waiting on program memory

   // Architectural registers
   reg  [7:0]  stack_top_reg;
   reg  [7:0]  data_pointer_low;
   reg  [7:0]  data_pointer_high;
   reg  [7:0]  program_status_word;         // Bit 0 unused, parity is live
   reg  [7:0]  main_operand_reg;
   reg  [7:0]  aux_operand_reg;
   reg         state_reg;                   // Operation sequencer
   reg         code_to_main_reg;            // Code byte also loads main

   // Next values
   reg  [7:0]  stack_top_next;
   reg  [7:0]  dpl_next;
   reg  [7:0]  dph_next;
   reg  [7:0]  psw_next;
   reg  [7:0]  main_next;
   reg  [7:0]  aux_next;
   reg         state_next;
   reg         code_to_main_next;
   reg         op_done_next;
   reg  [7:0]  rd_data_next;
   reg  [15:0] pc_next;
   reg  [15:0] code_addr_next;
   reg         code_rd_next;

   // Memories: internal scratch pad and expanded RAM, kept apart
   reg  [7:0]  iram_mem [0:255];
   reg  [7:0]  expanded_ram_mem [0:255];

   // Operand path
   wire [1:0]  bank_sel;                    // Selected register bank
   wire [7:0]  bank_reg0;                   // Bank register 0
   wire [7:0]  bank_reg1;                   // Bank register 1
   wire [15:0] data_pointer;                // Full 16-bit pointer
   wire        odd_ones;                    // Live parity of main
   wire [7:0]  status_view;                 // Status word as read
   wire [7:0]  code_byte;                   // Program byte, range checked
   wire [7:0]  bit_byte_addr;               // Byte holding addressed bit
   reg  [7:0]  eff_addr;                    // Effective data address
   reg  [7:0]  sfr_sel;                     // SFR read select
   reg  [7:0]  sfr_val;                     // SFR read value
   reg  [7:0]  operand;                     // Fetched operand
   reg  [7:0]  bit_byte;                    // Byte for bit access
   reg         bit_val;                     // Addressed bit
   reg  [7:0]  bit_new;                     // Byte with bit replaced
   wire        is_expanded_ram;                     // Expanded RAM access
   wire        is_sfr;                      // SFR space access
   reg  [8:0]  alu_sum;                     // Add/sub result with carry
   reg  [4:0]  alu_low;                     // Low nibble with carry
   reg         alu_cin;                     // Carry or borrow in
   wire [15:0] mul_prod;                    // Main times aux

   // Memory write controls
   reg         iram_we;
   reg         expanded_ram_we;
   reg  [7:0]  mem_wa;
   reg  [7:0]  mem_wd;
   reg         sfr_we;
   reg  [7:0]  sfr_wa;
   reg  [7:0]  sfr_wd;

   // Bank registers live in the lowest 32 bytes of RAM
   assign bank_sel  = program_status_word[`CCRA_PSW_BANK_HI:
                                          `CCRA_PSW_BANK_LO];
   assign bank_reg0 = iram_mem[{3'b000, bank_sel, 3'b000}];
   assign bank_reg1 = iram_mem[{3'b000, bank_sel, 3'b001}];
   assign data_pointer = {data_pointer_high, data_pointer_low};
   // Parity is derived, so it can never lag the main operand
   assign odd_ones    = ^main_operand_reg;
   assign status_view = {program_status_word[7:1], odd_ones};
   // No external program bus exists; reads past the end see fill
   assign code_byte = (code_addr_reg < `CCRA_CODE_SIZE) ?
                      code_rdata : `CCRA_CODE_FILL;
   // Bit addresses below 80H map into RAM 20H-2FH, others into
   // SFRs whose address ends in 0H or 8H
   assign bit_byte_addr = op_addr[7] ? {op_addr[7:3], 3'b000} :
                          {`CCRA_BITRAM_BASE, op_addr[6:3]};
   assign is_expanded_ram = (op_mode == `CCRA_MD_XIND_R) ||
                    (op_mode == `CCRA_MD_XIND_DP);
   // Upper half goes to SFRs only when directly addressed
   assign is_sfr  = (op_mode == `CCRA_MD_DIR) && eff_addr[7];
   assign mul_prod = main_operand_reg * aux_operand_reg;
   assign op_ready = (state_reg == ST_IDLE);

   // Effective address per addressing mode
   always @* begin
      case (op_mode)
         `CCRA_MD_DIR:     eff_addr = op_addr;
         `CCRA_MD_IND_R:   eff_addr = op_addr[0] ? bank_reg1 :
                                      bank_reg0;
         `CCRA_MD_IND_SP:  eff_addr = stack_top_reg;
         `CCRA_MD_REG:     eff_addr = {3'b000, bank_sel,
                                       op_addr[2:0]};
         `CCRA_MD_XIND_R:  eff_addr = op_addr[0] ? bank_reg1 :
                                      bank_reg0;
         // Only 256 bytes exist, so the high pointer byte is unused
         `CCRA_MD_XIND_DP: eff_addr = data_pointer[7:0];
         default:          eff_addr = op_addr;
      endcase
   end

   // SFR read mux; unmapped SFR addresses read as zero
   always @* begin
      sfr_sel = (op_code == `CCRA_OP_BIT) ? bit_byte_addr : eff_addr;
      case (sfr_sel)
         `CCRA_SFR_STACK: sfr_val = stack_top_reg;
         `CCRA_SFR_DPL:   sfr_val = data_pointer_low;
         `CCRA_SFR_DPH:   sfr_val = data_pointer_high;
         `CCRA_SFR_PSW:   sfr_val = status_view;
         `CCRA_SFR_MAIN:  sfr_val = main_operand_reg;
         `CCRA_SFR_AUX:   sfr_val = aux_operand_reg;
         default:         sfr_val = 8'h00;
      endcase
   end

   // Operand fetch and bit extraction
   always @* begin
      if (op_mode == `CCRA_MD_IMM)
         operand = op_addr;
      else if (is_expanded_ram)
         operand = expanded_ram_mem[eff_addr];
      else if (is_sfr)
         operand = sfr_val;
      else
         operand = iram_mem[eff_addr];
      bit_byte = op_addr[7] ? sfr_val : iram_mem[bit_byte_addr];
      bit_val  = bit_byte[op_addr[2:0]];
      bit_new  = bit_byte;
      bit_new[op_addr[2:0]] = program_status_word[`CCRA_PSW_CARRY];
   end

   // Adder with carry and half carry out of bit 3
   always @* begin
      alu_cin = (op_code == `CCRA_OP_ADD) ? 1'b0 :
                program_status_word[`CCRA_PSW_CARRY];
      if (op_code == `CCRA_OP_SUBB) begin
         alu_sum = {1'b0, main_operand_reg} - {1'b0, operand} -
                   {8'h00, alu_cin};
         alu_low = {1'b0, main_operand_reg[3:0]} -
                   {1'b0, operand[3:0]} - {4'h0, alu_cin};
      end else begin
         alu_sum = {1'b0, main_operand_reg} + {1'b0, operand} +
                   {8'h00, alu_cin};
         alu_low = {1'b0, main_operand_reg[3:0]} +
                   {1'b0, operand[3:0]} + {4'h0, alu_cin};
      end
   end

   // Operation sequencer: most operations finish in one clock,
   // program memory reads take two
   always @* begin
      stack_top_next    = stack_top_reg;
      dpl_next          = data_pointer_low;
      dph_next          = data_pointer_high;
      psw_next          = program_status_word;
      main_next         = main_operand_reg;
      aux_next          = aux_operand_reg;
      state_next        = state_reg;
      code_to_main_next = code_to_main_reg;
      op_done_next      = 1'b0;
      rd_data_next      = rd_data_reg;
      pc_next           = program_counter_reg;
      code_addr_next    = code_addr_reg;
      code_rd_next      = 1'b0;
      iram_we = 1'b0;
      expanded_ram_we = 1'b0;
      mem_wa  = eff_addr;
      mem_wd  = op_data;
      sfr_we  = 1'b0;
      sfr_wa  = eff_addr;
      sfr_wd  = op_data;
      case (state_reg)
         ST_CODE: begin
            // Program byte arrives one clock after the address
            rd_data_next = code_byte;
            if (code_to_main_reg)
               main_next = code_byte;
            op_done_next = 1'b1;
            state_next   = ST_IDLE;
         end
         ST_IDLE: begin
            if (op_valid) begin
               op_done_next = 1'b1;
               case (op_code)
                  `CCRA_OP_READ: begin
                     rd_data_next = operand;
                  end
                  `CCRA_OP_WRITE: begin
                     // An immediate is not a place, so nothing is stored
                     if (is_expanded_ram)
                        expanded_ram_we = 1'b1;
                     else if (is_sfr)
                        sfr_we = 1'b1;
                     else if (op_mode != `CCRA_MD_IMM)
                        iram_we = 1'b1;
                  end
                  `CCRA_OP_PUSH: begin
                     stack_top_next = stack_top_reg + 8'h01;
                     mem_wa  = stack_top_reg + 8'h01;
                     iram_we = 1'b1;
                  end
                  `CCRA_OP_POP: begin
                     rd_data_next   = iram_mem[stack_top_reg];
                     stack_top_next = stack_top_reg - 8'h01;
                  end
                  `CCRA_OP_ADD, `CCRA_OP_ADDC, `CCRA_OP_SUBB: begin
                     main_next = alu_sum[7:0];
                     psw_next[`CCRA_PSW_CARRY] = alu_sum[8];
                     psw_next[`CCRA_PSW_HALF]  = alu_low[4];
                     if (op_code == `CCRA_OP_SUBB)
                        psw_next[`CCRA_PSW_EXCESS] =
                           (main_operand_reg[7] != operand[7]) &&
                           (alu_sum[7] != main_operand_reg[7]);
                     else
                        psw_next[`CCRA_PSW_EXCESS] =
                           (main_operand_reg[7] == operand[7]) &&
                           (alu_sum[7] != main_operand_reg[7]);
                  end
                  `CCRA_OP_MUL: begin
                     // Aux receives the high byte of the product
                     main_next = mul_prod[7:0];
                     aux_next  = mul_prod[15:8];
                     psw_next[`CCRA_PSW_CARRY]  = 1'b0;
                     psw_next[`CCRA_PSW_EXCESS] = |mul_prod[15:8];
                  end
                  `CCRA_OP_BIT: begin
                     case (op_data[1:0])
                        `CCRA_BF_LOAD:
                           psw_next[`CCRA_PSW_CARRY] = bit_val;
                        `CCRA_BF_AND:
                           psw_next[`CCRA_PSW_CARRY] =
                              program_status_word[`CCRA_PSW_CARRY] &
                              bit_val;
                        `CCRA_BF_OR:
                           psw_next[`CCRA_PSW_CARRY] =
                              program_status_word[`CCRA_PSW_CARRY] |
                              bit_val;
                        default: begin
                           // Store carry into the addressed bit
                           mem_wa = bit_byte_addr;
                           mem_wd = bit_new;
                           sfr_wa = bit_byte_addr;
                           sfr_wd = bit_new;
                           if (op_addr[7])
                              sfr_we = 1'b1;
                           else
                              iram_we = 1'b1;
                        end
                     endcase
                  end
                  `CCRA_OP_MOVC: begin
                     // Table read only; there is no program write path
                     code_addr_next = (op_mode[0] ? program_counter_reg :
                                      data_pointer) +
                                      {8'h00, main_operand_reg};
                     code_rd_next      = 1'b1;
                     code_to_main_next = 1'b1;
                     op_done_next      = 1'b0;
                     state_next        = ST_CODE;
                  end
                  `CCRA_OP_FETCH: begin
                     code_addr_next    = program_counter_reg;
                     pc_next           = program_counter_reg + 16'h0001;
                     code_rd_next      = 1'b1;
                     code_to_main_next = 1'b0;
                     op_done_next      = 1'b0;
                     state_next        = ST_CODE;
                  end
                  `CCRA_OP_JMPIDX: begin
                     pc_next = data_pointer +
                               {8'h00, main_operand_reg};
                  end
                  `CCRA_OP_VECTOR: begin
                     pc_next = `CCRA_VEC_BASE +
                               {11'h000, op_addr[1:0], 3'b000};
                  end
                  default: begin
                     op_done_next = 1'b1;
                  end
               endcase
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
      // Byte writes into the SFR space; parity bit is not storable
      if (sfr_we) begin
         case (sfr_wa)
            `CCRA_SFR_STACK: stack_top_next = sfr_wd;
            `CCRA_SFR_DPL:   dpl_next = sfr_wd;
            `CCRA_SFR_DPH:   dph_next = sfr_wd;
            `CCRA_SFR_PSW:   psw_next = {sfr_wd[7:1], 1'b0};
            `CCRA_SFR_MAIN:  main_next = sfr_wd;
            `CCRA_SFR_AUX:   aux_next = sfr_wd;
            default:         psw_next = psw_next;
         endcase
      end
   end

   // Register state with asynchronous reset
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stack_top_reg       <= `CCRA_RST_STACK;
         data_pointer_low    <= `CCRA_RST_ZERO;
         data_pointer_high   <= `CCRA_RST_ZERO;
         program_status_word <= `CCRA_RST_ZERO;
         main_operand_reg    <= `CCRA_RST_ZERO;
         aux_operand_reg     <= `CCRA_RST_ZERO;
         state_reg           <= ST_IDLE;
         code_to_main_reg    <= 1'b0;
         op_done_reg         <= 1'b0;
         rd_data_reg         <= `CCRA_RST_ZERO;
         program_counter_reg <= `CCRA_RST_PC;
         code_addr_reg       <= `CCRA_RST_PC;
         code_rd_reg         <= 1'b0;
      end else begin
         stack_top_reg       <= stack_top_next;
         data_pointer_low    <= dpl_next;
         data_pointer_high   <= dph_next;
         program_status_word <= psw_next;
         main_operand_reg    <= main_next;
         aux_operand_reg     <= aux_next;
         state_reg           <= state_next;
         code_to_main_reg    <= code_to_main_next;
         op_done_reg         <= op_done_next;
         rd_data_reg         <= rd_data_next;
         program_counter_reg <= pc_next;
         code_addr_reg       <= code_addr_next;
         code_rd_reg         <= code_rd_next;
      end
   end

   // Memory arrays carry no reset; contents are undefined at start
   always @(posedge sys_clk) begin
      if (iram_we)
         iram_mem[mem_wa] <= mem_wd;
      if (expanded_ram_we)
         expanded_ram_mem[mem_wa] <= mem_wd;
   end

endmodule

`default_nettype wire

// ### verilog/ccra_map.vh
// Offsets, field positions, codes and reset values for the core registers
`ifndef CCRA_MAP_VH
`define CCRA_MAP_VH
// Special function register offsets
`define CCRA_SFR_STACK     8'h81
`define CCRA_SFR_DPL       8'h82
`define CCRA_SFR_DPH       8'h83
`define CCRA_SFR_PSW       8'hd0
`define CCRA_SFR_MAIN      8'he0
`define CCRA_SFR_AUX       8'hf0
// Reset values
`define CCRA_RST_STACK     8'h07
`define CCRA_RST_ZERO      8'h00
`define CCRA_RST_PC        16'h0000
// Status word bit positions
`define CCRA_PSW_CARRY     7
`define CCRA_PSW_HALF      6
`define CCRA_PSW_BANK_HI   4
`define CCRA_PSW_BANK_LO   3
`define CCRA_PSW_EXCESS    2
// Operation codes
`define CCRA_OP_NOP        4'h0
`define CCRA_OP_READ       4'h1
`define CCRA_OP_WRITE      4'h2
`define CCRA_OP_PUSH       4'h3
`define CCRA_OP_POP        4'h4
`define CCRA_OP_ADD        4'h5
`define CCRA_OP_ADDC       4'h6
`define CCRA_OP_SUBB       4'h7
`define CCRA_OP_MUL        4'h8
`define CCRA_OP_BIT        4'h9
`define CCRA_OP_MOVC       4'ha
`define CCRA_OP_FETCH      4'hb
`define CCRA_OP_JMPIDX     4'hc
`define CCRA_OP_VECTOR     4'hd
// Addressing modes
`define CCRA_MD_DIR        3'h0
`define CCRA_MD_IND_R      3'h1
`define CCRA_MD_IND_SP     3'h2
`define CCRA_MD_REG        3'h3
`define CCRA_MD_IMM        3'h4
`define CCRA_MD_XIND_R     3'h5
`define CCRA_MD_XIND_DP    3'h6
// Bit operation functions
`define CCRA_BF_LOAD       2'h0
`define CCRA_BF_STORE      2'h1
`define CCRA_BF_AND        2'h2
`define CCRA_BF_OR         2'h3
// Memory map
`define CCRA_CODE_SIZE     16'h3e00
`define CCRA_VEC_BASE      16'h0003
`define CCRA_BITRAM_BASE   4'h2
`define CCRA_CODE_FILL     8'hff
`endif

// ### dv/ccra_chk.sv
// Concurrent checks on the core's operation and program memory ports
`timescale 1ns/10ps
`default_nettype none
`include "ccra_map.vh"
module ccra_chk (
   input wire logic        sys_clk,
   input wire logic        reset,
   input wire logic        op_valid,
   input wire logic [3:0]  op_code,
   input wire logic [2:0]  op_mode,
   input wire logic [7:0]  op_addr,
   input wire logic [7:0]  op_data,
   input wire logic [7:0]  code_rdata,
   input wire logic        op_ready,
   input wire logic        op_done_reg,
   input wire logic [7:0]  rd_data_reg,
   input wire logic [15:0] program_counter_reg,
   input wire logic [15:0] code_addr_reg,
   input wire logic        code_rd_reg
);
   // Accepted request, and whether it waits on program memory
   wire       take    = op_valid && op_ready;
   wire       code_op = op_code == `CCRA_OP_MOVC || op_code == `CCRA_OP_FETCH;
   wire       is_fast = op_code != `CCRA_OP_NOP && op_code <= `CCRA_OP_VECTOR;
   wire [1:0] vec_idx = op_addr[1:0];
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   AST_PC_START: assert property ($past(reset) |->
      program_counter_reg == 16'h0000) else $error("pc not at entry");
   AST_VECTOR: assert property (take && op_code == `CCRA_OP_VECTOR |=>
      program_counter_reg == 16'h0003 + {11'h000, $past(vec_idx), 3'b000})
      else $error("vector address wrong");
   AST_CODE_TIMING: assert property (take && code_op |=>
      code_rd_reg && !op_ready && !op_done_reg ##1 op_done_reg && op_ready)
      else $error("code read timing wrong");
   AST_FAST_DONE: assert property (take && is_fast && !code_op |=>
      op_done_reg && !code_rd_reg) else $error("one cycle op late");
   AST_FETCH_ADDR: assert property (take && op_code == `CCRA_OP_FETCH |=>
      code_addr_reg == $past(program_counter_reg) &&
      program_counter_reg == $past(program_counter_reg) + 16'h0001)
      else $error("fetch address or pc step wrong");
   AST_CODE_CAUSE: assert property (code_rd_reg |->
      $past(take) && $past(code_op)) else $error("stray code read");
   AST_READY_GAP: assert property (!op_ready |=> op_ready)
      else $error("ready low too long");
   AST_DONE_CAUSE: assert property (op_done_reg |->
      $past(code_rd_reg) || ($past(take) && !$past(code_op)))
      else $error("done without request");
   AST_ADDR_HOLD: assert property ($changed(code_addr_reg) |->
      code_rd_reg) else $error("code address moved without read");
   COV_VECTOR: cover property (take && op_code == `CCRA_OP_VECTOR);
   COV_CODE: cover property (take && code_op ##2 op_done_reg);
   COV_JUMP: cover property (take && op_code == `CCRA_OP_JMPIDX);
endmodule
bind ccra_core ccra_chk ccra_chk_i (.sys_clk(sys_clk), .reset(reset),
   .op_valid(op_valid), .op_code(op_code), .op_mode(op_mode),
   .op_addr(op_addr), .op_data(op_data), .code_rdata(code_rdata),
   .op_ready(op_ready), .op_done_reg(op_done_reg), .rd_data_reg(rd_data_reg),
   .program_counter_reg(program_counter_reg), .code_addr_reg(code_addr_reg),
   .code_rd_reg(code_rd_reg));
`default_nettype wire

// ### dv/ccra_flash_model.sv
// Behavioural program flash answering the core's code reads
`timescale 1ns/10ps
`default_nettype none
module ccra_flash_model (
   input  wire logic        sys_clk,
   input  wire logic        code_rd_reg,
   input  wire logic [15:0] code_addr_reg,
   output wire logic [7:0]  code_rdata
);
   // Last byte served; its inverse shows between reads
   logic [7:0] last_q = 8'h00;
   // Fixed content from the address alone, never written
   wire  [7:0] byte_at = code_addr_reg[7:0] ^ code_addr_reg[15:8] ^ 8'h3c;
   // Stale data never matches, so a late sample is caught
   assign code_rdata = code_rd_reg ? byte_at : ~last_q;
   // Track the served byte
   always @(posedge sys_clk) if (code_rd_reg) last_q <= byte_at;
endmodule
`default_nettype wire

// ### dv/ccra_core_tb_top.sv
// Self-checking bench for the core register set and addressing
`timescale 1ns/10ps
`default_nettype none
`include "ccra_map.vh"
module ccra_core_tb_top;
   reg         sys_clk  = 1'b0;
   reg         reset    = 1'b1;
   reg         op_valid = 1'b0;
   reg  [3:0]  op_code  = 4'h0;
   reg  [2:0]  op_mode  = 3'h0;
   reg  [7:0]  op_addr  = 8'h00;
   reg  [7:0]  op_data  = 8'h00;
   wire [7:0]  code_rdata, rd_data_reg;
   wire        op_ready, op_done_reg, code_rd_reg;
   wire [15:0] program_counter_reg, code_addr_reg;
   // Reference model state
   reg  [7:0]  iram [0:255];
   reg  [7:0]  expanded_ram [0:255];
   reg  [7:0]  m_sp, m_dpl, m_dph, m_psw, m_acc, m_b, m_rd;
   reg  [15:0] m_pc, m_ca;
   reg  [55:0] sfr_tab = 56'h81_82_83_d0_e0_f0_85;
   integer     num_errors = 0, comparisons = 0, seed = 32'hc68b0cf6, i, j, r;
   always #25 sys_clk = ~sys_clk;
   ccra_core ccra_core_i (.sys_clk(sys_clk), .reset(reset),
      .op_valid(op_valid), .op_code(op_code), .op_mode(op_mode),
      .op_addr(op_addr), .op_data(op_data), .code_rdata(code_rdata),
      .op_ready(op_ready), .op_done_reg(op_done_reg),
      .rd_data_reg(rd_data_reg), .program_counter_reg(program_counter_reg),
      .code_addr_reg(code_addr_reg), .code_rd_reg(code_rd_reg));
   ccra_flash_model ccra_flash_model_i (.sys_clk(sys_clk),
      .code_rd_reg(code_rd_reg), .code_addr_reg(code_addr_reg),
      .code_rdata(code_rdata));
   // Expected flash byte; beyond the on-chip size the core gives all ones
   function [7:0] flash_byte(input [15:0] a);
      flash_byte = (a >= `CCRA_CODE_SIZE) ? 8'hff : a[7:0] ^ a[15:8] ^ 8'h3c;
   endfunction
   function [7:0] sfr_rd(input [7:0] a);
      case (a)
         8'h81: sfr_rd = m_sp;
         8'h82: sfr_rd = m_dpl;
         8'h83: sfr_rd = m_dph;
         8'hd0: sfr_rd = {m_psw[7:1], ^m_acc};
         8'he0: sfr_rd = m_acc;
         8'hf0: sfr_rd = m_b;
         default: sfr_rd = 8'h00;
      endcase
   endfunction
   // Bank register 0 or 1 of the selected bank
   function [7:0] ri(input b);
      ri = iram[{m_psw[4:3], 2'b00, b}];
   endfunction
   function [7:0] rdv(input [2:0] m, input [7:0] a);
      case (m)
         3'h0: rdv = a[7] ? sfr_rd(a) : iram[a];
         3'h1: rdv = iram[ri(a[0])];
         3'h2: rdv = iram[m_sp];
         3'h3: rdv = iram[{m_psw[4:3], a[2:0]}];
         3'h4: rdv = a;
         3'h5: rdv = expanded_ram[ri(a[0])];
         default: rdv = expanded_ram[m_dpl];
      endcase
   endfunction
   task wrv(input [2:0] m, input [7:0] a, input [7:0] d);
      case (m)
         3'h0: if (!a[7]) iram[a] = d;
            else case (a)
               8'h81: m_sp = d;
               8'h82: m_dpl = d;
               8'h83: m_dph = d;
               8'hd0: m_psw = d;
               8'he0: m_acc = d;
               8'hf0: m_b = d;
               default: ;
            endcase
         3'h1: iram[ri(a[0])] = d;
         3'h2: iram[m_sp] = d;
         3'h3: iram[{m_psw[4:3], a[2:0]}] = d;
         3'h5: expanded_ram[ri(a[0])] = d;
         3'h6: expanded_ram[m_dpl] = d;
         default: ;
      endcase
   endtask
   // Effect of one operation on the model
   task model(input [3:0] c, input [2:0] m, input [7:0] a, input [7:0] d);
      integer v, s, h, cin;
      reg [7:0] ba, bv;
      v = rdv(m, a);
      cin = (c == `CCRA_OP_ADD) ? 0 : m_psw[7];
      ba = a[7] ? {a[7:3], 3'b000} : 8'h20 + a[6:3];
      bv = rdv(3'h0, ba);
      case (c)
         4'h1: m_rd = v;
         4'h2: wrv(m, a, d);
         4'h3: begin m_sp = m_sp + 1; iram[m_sp] = d; end
         4'h4: begin m_rd = iram[m_sp]; m_sp = m_sp - 1; end
         4'h5, 4'h6, 4'h7: begin
            s = (c == 4'h7) ? m_acc - v - cin : m_acc + v + cin;
            h = (c == 4'h7) ? m_acc % 16 - v % 16 - cin : m_acc % 16 + v % 16 + cin;
            m_psw[7] = s < 0 || s > 255;
            m_psw[6] = h < 0 || h > 15;
            m_psw[2] = (((c == 4'h7 ? m_acc : ~m_acc) ^ v) & (m_acc ^ s) & 128) != 0;
            m_acc = s[7:0];
         end
         4'h8: begin s = m_acc * m_b; m_acc = s[7:0]; m_b = s[15:8];
            m_psw[7] = 1'b0; m_psw[2] = s > 255; end
         4'h9: case (d[1:0])
            2'h0: m_psw[7] = bv[a[2:0]];
            2'h1: begin bv[a[2:0]] = m_psw[7]; wrv(3'h0, ba, bv); end
            2'h2: m_psw[7] = m_psw[7] & bv[a[2:0]];
            default: m_psw[7] = m_psw[7] | bv[a[2:0]];
         endcase
         4'ha: begin m_ca = (m[0] ? m_pc : {m_dph, m_dpl}) + m_acc;
            m_acc = flash_byte(m_ca); m_rd = m_acc; end
         4'hb: begin m_ca = m_pc; m_rd = flash_byte(m_pc); m_pc = m_pc + 1; end
         4'hc: m_pc = {m_dph, m_dpl} + m_acc;
         4'hd: m_pc = 16'h0003 + {a[1:0], 3'b000};
         default: ;
      endcase
   endtask
   task chk8(input string n, input [7:0] e, input [7:0] s);
      comparisons = comparisons + 1;
      if (s !== e) begin num_errors = num_errors + 1;
         $display("ERROR %0s expected %h seen %h", n, e, s); end
   endtask
   task chk16(input string n, input [15:0] e, input [15:0] s);
      comparisons = comparisons + 1;
      if (s !== e) begin num_errors = num_errors + 1;
         $display("ERROR %0s expected %h seen %h", n, e, s); end
   endtask
   task print_verdict;
      $display("mismatches %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // One request, a bounded wait for done, then read data, pc and code address compared
   task do_op(input [3:0] c, input [2:0] m, input [7:0] a, input [7:0] d);
      integer k;
      @(posedge sys_clk);
      op_valid <= 1'b1;
      op_code <= c;
      op_mode <= m;
      op_addr <= a;
      op_data <= d;
      k = 0;
      // Drop the request at the taking edge; done is a one-clock pulse
      do begin @(posedge sys_clk); op_valid <= 1'b0; #1; k = k + 1; end
      while (op_done_reg !== 1'b1 && k < 4);
      if (op_done_reg !== 1'b1) begin chk8("done", 8'h01, {7'h00, op_done_reg}); print_verdict; end
      model(c, m, a, d);
      chk8("rd_data", m_rd, rd_data_reg);
      chk16("pc", m_pc, program_counter_reg);
      chk16("code_addr", m_ca, code_addr_reg);
   endtask
   // Reset held four cycles; RAM is not relied on afterwards
   task do_reset;
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      {m_sp, m_dpl, m_dph, m_psw, m_acc, m_b, m_rd} = {8'h07, 48'h0};
      {m_pc, m_ca} = 32'h0;
   endtask
   initial begin
      do_reset;
      for (j = 0; j < 7; j++) do_op(4'h1, 3'h0, sfr_tab[8*j +: 8], 8'h00);
      $display("reset values done");
      // Fill both RAMs through stack and pointer so no read is undefined
      for (i = 0; i < 256; i++) begin
         do_op(4'h2, 3'h0, 8'h81, i[7:0]);
         do_op(4'h2, 3'h2, 8'h00, $random(seed));
         do_op(4'h2, 3'h0, 8'h82, i[7:0]);
         do_op(4'h2, 3'h6, 8'h00, $random(seed));
      end
      $display("ram fill done");
      // Random mix; arithmetic keeps to internal operand modes
      for (i = 0; i < 700; i++) begin
         r = {$random(seed)} % 13 + 1;
         j = {$random(seed)} % ((r >= 5 && r <= 7) ? 5 : 7);
         do_op(r[3:0], j[2:0], $random(seed), $random(seed));
         do_op(4'h1, 3'h0, 8'hd0, 8'h00);
      end
      $display("random mix done");
      // Table read at the last byte and the first byte past flash
      for (j = 0; j < 2; j++) begin
         do_op(4'h2, 3'h0, 8'h83, 8'h3d);
         do_op(4'h2, 3'h0, 8'h82, 8'hff);
         do_op(4'h2, 3'h0, 8'he0, j[7:0]);
         do_op(4'ha, 3'h0, 8'h00, 8'h00);
      end
      for (j = 0; j < 4; j++) do_op(4'hd, 3'h0, j[7:0], 8'h00);
      $display("boundary and vectors done");
      do_reset;
      for (j = 0; j < 7; j++) do_op(4'h1, 3'h0, sfr_tab[8*j +: 8], 8'h00);
      $display("second reset done");
      print_verdict;
   end
endmodule
`default_nettype wire
